// ---- hw/lfs_regs.svh ----
// register offsets, field positions, reset values and timing counts of the
// led fault status capture block; assumes a 25 MHz core clock
`ifndef LFS_REGS_SVH
`define LFS_REGS_SVH

`define LFS_CTRL_OFS 12'h000
`define LFS_STATUS_OFS 12'h004
`define LFS_ONOFF_OFS 12'h008
`define LFS_SHIFT_OFS 12'h00c

`define LFS_CTRL_CUR_LSB 0
`define LFS_CTRL_TIME_LSB 2
`define LFS_CTRL_SEL_LSB 4
`define LFS_CTRL_PSAVE_BIT 6
`define LFS_CTRL_RESET 32'h0000_0040

`define LFS_SEL_NONE 2'h0
`define LFS_SEL_OPEN 2'h1
`define LFS_SEL_SHORT 2'h2
`define LFS_SEL_LEAK 2'h3
`define LFS_CUR_OFF 2'h0

`define LFS_CLK_PERIOD_NS 40
`define LFS_WAKE_DELAY_NS 20000
`define LFS_WAKE_CYCLES ((`LFS_WAKE_DELAY_NS + `LFS_CLK_PERIOD_NS - 1) / `LFS_CLK_PERIOD_NS)
`define LFS_DET_TIME0_NS 1000
`define LFS_DET_TIME1_NS 2000
`define LFS_DET_TIME2_NS 4000
`define LFS_DET_TIME3_NS 8000
`define LFS_DET_CYCLES(ns) ((ns) / `LFS_CLK_PERIOD_NS)

`endif

// ---- hw/lfs_pkg.sv ----
// types shared by the led fault status capture block
// assumes the offsets and counts of lfs_regs.svh
package lfs_pkg;
    typedef struct packed {
        logic power_save_en;
        logic [1:0] status_load_selector;
        logic [1:0] off_state_detect_time_sel;
        logic [1:0] off_state_test_current_sel;
    } lfs_ctrl_t;

    typedef struct packed {
        logic load_armed;
        logic leak_source_on;
        logic off_state_sinking;
        logic power_save;
        logic reference_short_flag;
        logic pre_thermal_warning;
        logic thermal_error_flag;
    } lfs_flags_t;

    typedef enum logic [0:0] {
        LFS_IDLE = 1'b0,
        LFS_SINK = 1'b1
    } lfs_idm_state_t;
endpackage

// ---- hw/lfs_fault_status.sv ----
// led fault status capture: status holder, common shift register and flags
// assumes async pins from the host and analog comparators; apb on ref_clk_in
`include "lfs_regs.svh"

module lfs_fault_status
    import lfs_pkg::*;
#(
    parameter int CH = 16,
    parameter int WAKE_CYCLES = `LFS_WAKE_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic shift_clock_in,
    input wire logic serial_data_in,
    input wire logic latch_strobe_in,
    input wire logic output_blank_in,
    input wire logic thermal_shutdown_in,
    input wire logic pre_thermal_warning_in,
    input wire logic current_reference_short_in,
    input wire logic [CH-1:0] open_led_detect_in,
    input wire logic [CH-1:0] shorted_led_detect_in,
    input wire logic [CH-1:0] output_leak_detect_in,
    output logic serial_data_output_out,
    output logic [CH-1:0] channel_output_out,
    output logic off_state_sink_out,
    output logic [CH-1:0] leak_source_out,
    output logic power_save_out
);
    localparam int SR_W = CH + 1;
    localparam int SW = 3 * CH + 7;
    localparam int CW = 12;
    localparam logic [CW-1:0] DET0 = CW'(`LFS_DET_CYCLES(`LFS_DET_TIME0_NS));
    localparam logic [CW-1:0] DET1 = CW'(`LFS_DET_CYCLES(`LFS_DET_TIME1_NS));
    localparam logic [CW-1:0] DET2 = CW'(`LFS_DET_CYCLES(`LFS_DET_TIME2_NS));
    localparam logic [CW-1:0] DET3 = CW'(`LFS_DET_CYCLES(`LFS_DET_TIME3_NS));
    localparam logic [CW-1:0] WAKE = CW'(WAKE_CYCLES);

    // two-stage synchroniser for every host and comparator pin; only stage two is read by logic
    logic [SW-1:0] async_w;
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [2:0] prev_q;

    assign async_w = {shift_clock_in, serial_data_in, latch_strobe_in, output_blank_in,
                      thermal_shutdown_in, pre_thermal_warning_in,
                      current_reference_short_in, open_led_detect_in,
                      shorted_led_detect_in, output_leak_detect_in};

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= async_w;
            sync_q <= meta_q;
            // shift clock, latch strobe, and the blank strobe inverted so its reset value is idle
            prev_q <= {sync_q[SW-1], sync_q[SW-3], ~sync_q[SW-4]};
        end
    end

    wire sclk_w = sync_q[SW-1];
    wire sin_w = sync_q[SW-2];
    wire lat_w = sync_q[SW-3];
    wire blank_w = sync_q[SW-4];
    wire tsd_w = sync_q[SW-5];
    wire ptw_w = sync_q[SW-6];
    wire isf_w = sync_q[SW-7];
    wire [CH-1:0] open_w = sync_q[3*CH-1 -: CH];
    wire [CH-1:0] short_w = sync_q[2*CH-1 -: CH];
    wire [CH-1:0] leak_w = sync_q[CH-1:0];

    // prev_q holds sclk, lat and the inverted blank of the previous cycle
    wire sclk_rise_w = sclk_w & ~prev_q[2];
    wire lat_rise_w = lat_w & ~prev_q[1];
    wire blank_rise_w = blank_w & prev_q[0];
    wire blank_fall_w = ~blank_w & ~prev_q[0];

    // apb slave, zero wait states
    lfs_ctrl_t ctrl_q;
    logic [SR_W-1:0] shift_q;
    logic [CH-1:0] onoff_q;
    logic [CH-1:0] holder_q;
    logic tef_q;
    logic ptw_q;
    logic ps_q;
    logic armed_q;
    logic [CW-1:0] wake_q;
    logic [CW-1:0] det_cnt_q;
    lfs_idm_state_t idm_q;
    lfs_flags_t flags_w;

    wire apb_acc_w = psel_in & penable_in;
    wire hit_ctrl_w = paddr_in == `LFS_CTRL_OFS;
    wire hit_stat_w = paddr_in == `LFS_STATUS_OFS;
    wire hit_onoff_w = paddr_in == `LFS_ONOFF_OFS;
    wire hit_shift_w = paddr_in == `LFS_SHIFT_OFS;
    wire hit_any_w = hit_ctrl_w | hit_stat_w | hit_onoff_w | hit_shift_w;
    wire ctrl_wr_w = apb_acc_w & pwrite_in & hit_ctrl_w;

    assign pready_out = 1'b1;
    assign pslverr_out = apb_acc_w & ~hit_any_w;
    assign prdata_out = hit_ctrl_w ? 32'(ctrl_q) :
                        hit_stat_w ? {9'h0, flags_w, holder_q} :
                        hit_onoff_w ? 32'(onoff_q) :
                        hit_shift_w ? 32'(shift_q) : 32'h0000_0000;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ctrl_q <= lfs_ctrl_t'(`LFS_CTRL_RESET);
        end else if (ctrl_wr_w) begin
            ctrl_q <= lfs_ctrl_t'(pwdata_in[6:0]);
        end
    end

    // detection modes
    wire idm_en_w = ctrl_q.off_state_test_current_sel != `LFS_CUR_OFF;
    wire [1:0] sel_w = ctrl_q.status_load_selector;
    wire awake_w = ~ps_q & (wake_q == '0);
    // leak source only with selector 11, blank low, not in or just after power-save
    wire leak_on_w = (sel_w == `LFS_SEL_LEAK) & ~blank_w & ~idm_en_w & awake_w;
    wire [CH-1:0] det_mask_w = (onoff_q | {CH{idm_en_w}}) & {CH{awake_w}};

    // per-channel comparator results folded into the selected detector word
    logic [CH-1:0] open_bits_w;
    logic [CH-1:0] short_bits_w;
    logic [CH-1:0] leak_bits_w;
    generate
        for (genvar i = 0; i < CH; i++) begin : g_ch
            assign open_bits_w[i] = (open_w[i] & det_mask_w[i]) | tsd_w;
            assign short_bits_w[i] = (short_w[i] & det_mask_w[i]) | ptw_w;
            // the registered source still shows the low-blank state at the blank rising edge
            assign leak_bits_w[i] = (leak_w[i] & leak_source_out[i]) | isf_w;
        end
    endgenerate

    wire [CH-1:0] detect_w = (sel_w == `LFS_SEL_OPEN) ? open_bits_w :
                             (sel_w == `LFS_SEL_SHORT) ? short_bits_w :
                             (sel_w == `LFS_SEL_LEAK) ? leak_bits_w : holder_q;

    // off-state test sinking, timed in core cycles from blank fall
    wire [CW-1:0] det_len_w = (ctrl_q.off_state_detect_time_sel == 2'h0) ? DET0 :
                              (ctrl_q.off_state_detect_time_sel == 2'h1) ? DET1 :
                              (ctrl_q.off_state_detect_time_sel == 2'h2) ? DET2 : DET3;
    wire det_done_w = det_cnt_q <= 12'h001;
    wire idm_stop_w = (idm_q == LFS_SINK) & (blank_rise_w | det_done_w);
    lfs_idm_state_t idm_d;

    always_comb begin
        idm_d = idm_q;
        case (idm_q)
            LFS_IDLE: begin
                if (blank_fall_w & idm_en_w & awake_w) begin
                    idm_d = LFS_SINK;
                end
            end
            LFS_SINK: begin
                if (idm_stop_w | ~idm_en_w) begin
                    idm_d = LFS_IDLE;
                end
            end
            default: idm_d = LFS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            idm_q <= LFS_IDLE;
            det_cnt_q <= '0;
        end else begin
            idm_q <= idm_d;
            if (blank_fall_w) begin
                det_cnt_q <= det_len_w;
            end else if (det_cnt_q != '0) begin
                det_cnt_q <= det_cnt_q - 12'h001;
            end
        end
    end

    // status holder: end of test sinking with idm, else blank rising edge
    wire hold_load_w = idm_en_w ? idm_stop_w : blank_rise_w;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            holder_q <= '0;
        end else if (hold_load_w && sel_w != `LFS_SEL_NONE) begin
            holder_q <= detect_w;
        end
    end

    // sticky thermal flags: set wins over the latch strobe clear
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            tef_q <= 1'b0;
            ptw_q <= 1'b0;
        end else begin
            tef_q <= tsd_w | (tef_q & ~lat_rise_w);
            ptw_q <= ptw_w | (ptw_q & ~lat_rise_w);
        end
    end

    // status word: the selected detector's global flag, when set, overrides the holder with all ones
    wire flag_sel_w = (sel_w == `LFS_SEL_OPEN) ? tef_q :
                      (sel_w == `LFS_SEL_SHORT) ? ptw_q :
                      (sel_w == `LFS_SEL_LEAK) ? isf_w : 1'b0;
    wire [CH-1:0] status_word_w = flag_sel_w ? {CH{1'b1}} : holder_q;

    // common shift register and on/off latch
    wire take_lat_w = lat_rise_w & armed_q;
    wire load_ok_w = take_lat_w & ~shift_q[SR_W-1];
    wire [CH-1:0] onoff_new_w = shift_q[CH-1:0];

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            shift_q <= '0;
            onoff_q <= '0;
            armed_q <= 1'b0;
        end else begin
            if (sclk_rise_w) begin
                shift_q <= {shift_q[SR_W-2:0], sin_w};
                armed_q <= 1'b1;
            end else if (take_lat_w) begin
                armed_q <= 1'b0;
                if (load_ok_w) begin
                    onoff_q <= onoff_new_w;
                    if (sel_w != `LFS_SEL_NONE) begin
                        shift_q[CH-1:0] <= status_word_w;
                    end
                end
            end
        end
    end

    // power-save entry on a latch with all channels off; leaves on shift clock
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ps_q <= 1'b0;
            wake_q <= '0;
        end else begin
            if (sclk_rise_w) begin
                if (ps_q) begin
                    wake_q <= WAKE;
                end
                ps_q <= 1'b0;
            end else if (load_ok_w && onoff_new_w == '0 && ctrl_q.power_save_en) begin
                ps_q <= 1'b1;
            end else if (wake_q != '0) begin
                wake_q <= wake_q - 12'h001;
            end
        end
    end

    // pin drivers; thermal shutdown and reference short force sinks off
    wire force_off_w = tsd_w | isf_w;
    wire [CH-1:0] chan_d_w = onoff_q & {CH{~blank_w & ~force_off_w & ~ps_q}};

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            channel_output_out <= '0;
            off_state_sink_out <= 1'b0;
            leak_source_out <= '0;
            power_save_out <= 1'b0;
        end else begin
            channel_output_out <= chan_d_w;
            off_state_sink_out <= (idm_d == LFS_SINK) & ~force_off_w;
            leak_source_out <= ~onoff_q & {CH{leak_on_w}};
            power_save_out <= ps_q;
        end
    end

    assign serial_data_output_out = shift_q[SR_W-1];

    assign flags_w.load_armed = armed_q;
    assign flags_w.leak_source_on = leak_on_w;
    assign flags_w.off_state_sinking = idm_q == LFS_SINK;
    assign flags_w.power_save = ps_q;
    assign flags_w.reference_short_flag = isf_w;
    assign flags_w.pre_thermal_warning = ptw_q;
    assign flags_w.thermal_error_flag = tef_q;
endmodule

// ---- tb/lfs_fault_status_properties.sv ----
// port-level temporal checks of the led fault status capture block
// assumes it is bound to lfs_fault_status and sees only its ports
module lfs_fault_status_checker
    import lfs_pkg::*;
#(
    parameter int CH = 16
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic shift_clock_in,
    input wire logic output_blank_in,
    input wire logic thermal_shutdown_in,
    input wire logic current_reference_short_in,
    input wire logic [CH-1:0] channel_output_out,
    input wire logic off_state_sink_out,
    input wire logic [CH-1:0] leak_source_out,
    input wire logic power_save_out
);
    logic [1:0] cur_q;
    logic [1:0] sel_q;
    wire logic ctrl_wr = psel_in && penable_in && pwrite_in && paddr_in == 12'h000;
    wire logic leak_on = |leak_source_out;
    // mirror of the test current and selector fields, taken from the bus so no internal view is needed
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cur_q <= 2'h0;
            sel_q <= 2'h0;
        end else if (ctrl_wr) begin
            cur_q <= pwdata_in[1:0];
            sel_q <= pwdata_in[5:4];
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_idm_off_idle: assert property ((cur_q == 2'h0)[*2] |-> !off_state_sink_out)
        else $error("sink active with test current off");
    a_sink_bounded: assert property ($rose(off_state_sink_out) |-> ##[1:201] !off_state_sink_out)
        else $error("sink outlived longest detect time");
    a_blank_idle: assert property (output_blank_in[*5] |-> !off_state_sink_out && !leak_on)
        else $error("test current while blanked");
    a_leak_sel: assert property ((sel_q != 2'h3)[*2] |-> !leak_on)
        else $error("leak source without leak selector");
    a_idm_no_leak: assert property (off_state_sink_out |-> !leak_on)
        else $error("leak source during off-state detect");
    a_leak_off_chan: assert property ((leak_source_out & channel_output_out) == '0)
        else $error("leak source on enabled channel");
    a_hot_off: assert property (thermal_shutdown_in[*5] |-> channel_output_out == '0)
        else $error("outputs on during shutdown");
    a_ref_short_off: assert property (current_reference_short_in[*5] |-> !(|channel_output_out))
        else $error("outputs on during reference short");
    a_wake_no_leak: assert property ($fell(power_save_out) |-> (!leak_on)[*8])
        else $error("leak source inside wake delay");
    a_psave_holds: assert property ((power_save_out && !shift_clock_in)[*5] |=> power_save_out)
        else $error("power-save left without shift clock");
    c_sink: cover property ($rose(off_state_sink_out));
    c_leak: cover property (leak_on);
    c_wake: cover property ($fell(power_save_out));
endmodule

bind lfs_fault_status lfs_fault_status_checker #(.CH(CH)) i_chk (.ref_clk_in, .reset_n_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .shift_clock_in, .output_blank_in,
    .thermal_shutdown_in, .current_reference_short_in, .channel_output_out, .off_state_sink_out,
    .leak_source_out, .power_save_out);

// ---- tb/lfs_host_model.sv ----
// host side of the serial link: shift clock, data, latch strobe and blank
// assumes the core clock as time base; pins change right after its rising edge
module lfs_host_model (
    input wire logic clk_in,
    input wire logic serial_data_output_in,
    output logic sclk_out = 1'b0,
    output logic sdata_out = 1'b0,
    output logic latch_out = 1'b0,
    output logic blank_out = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] got = 17'h00000;
    // msb first, 320 ns period; clock idles low between frames
    task automatic shift_word(input logic [16:0] w);
        for (int i = 16; i >= 0; i--) begin
            @(posedge clk_in);
            sdata_out <= w[i];
            repeat (3) @(posedge clk_in);
            got = {got[15:0], serial_data_output_in};
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        // released data line must not look like a held bit
        sdata_out <= ~sdata_out;
    endtask
    task automatic pulse_latch();
        repeat (4) @(posedge clk_in);
        latch_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        latch_out <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic set_blank(input logic v);
        @(posedge clk_in);
        blank_out <= v;
        repeat (6) @(posedge clk_in);
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the led fault status capture block
// assumes the host model drives the serial pins; apb is driven from here
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd_q;
    logic thermal_shutdown_in = 1'b0, pre_thermal_warning_in = 1'b0;
    logic current_reference_short_in = 1'b0;
    logic [15:0] open_led_detect_in = 16'h0, shorted_led_detect_in = 16'h0;
    logic [15:0] output_leak_detect_in = 16'h0, channel_output_out, leak_source_out;
    logic pready_out, pslverr_out, shift_clock_in, serial_data_in, latch_strobe_in;
    logic output_blank_in, serial_data_output_out, off_state_sink_out, power_save_out;
    int miscompares = 0;
    int n_checks = 0;
    always #20 ref_clk_in = ~ref_clk_in;
    lfs_fault_status #(.WAKE_CYCLES(20)) i_dut (.ref_clk_in, .reset_n_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .shift_clock_in,
        .serial_data_in, .latch_strobe_in, .output_blank_in, .thermal_shutdown_in,
        .pre_thermal_warning_in, .current_reference_short_in, .open_led_detect_in,
        .shorted_led_detect_in, .output_leak_detect_in, .serial_data_output_out,
        .channel_output_out, .off_state_sink_out, .leak_source_out, .power_save_out);
    lfs_host_model i_host (.clk_in(ref_clk_in), .serial_data_output_in(serial_data_output_out),
        .sclk_out(shift_clock_in), .sdata_out(serial_data_in), .latch_out(latch_strobe_in),
        .blank_out(output_blank_in));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // response and read data are taken at the rising edge that sees pready high
    task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] e = 32'h0, input logic [31:0] m = 32'hffff_ffff);
        logic err;
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
        end while (pready_out !== 1'b1);
        err = pslverr_out;
        rd_q = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        chk({31'h0, err}, {31'h0, a > 12'h00c});
        if (!w) chk(rd_q & m, e);
    endtask
    task automatic load(input logic [16:0] w);
        i_host.shift_word(w);
        i_host.pulse_latch();
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        ap(0, 12'h000, 0, 32'h40);
        ap(0, 12'h010, 0, 32'h0);
        ap(1, 12'h000, 32'h0);
        load(17'h000ff);
        ap(0, 12'h008, 0, 32'hff);
        open_led_detect_in <= 16'hf0f0;
        shorted_led_detect_in <= 16'h3c3c;
        output_leak_detect_in <= 16'h5a5a;
        for (int s = 1; s < 4; s++) begin
            ap(1, 12'h000, 32'(s << 4));
            i_host.set_blank(1'b0);
            if (s == 3) chk(leak_source_out, 16'hff00);
            i_host.set_blank(1'b1);
            load(17'h000ff);
            ap(0, 12'h00c, 0, s == 1 ? 32'hf0 : s == 2 ? 32'h3c : 32'h5a00);
        end
        output_leak_detect_in <= 16'hffff;
        i_host.set_blank(1'b0);
        i_host.set_blank(1'b1);
        i_host.pulse_latch();
        ap(0, 12'h00c, 0, 32'h5a00);
        i_host.shift_word(17'h1ffff);
        chk(i_host.got, 32'h5a00);
        i_host.pulse_latch();
        ap(0, 12'h008, 0, 32'hff);
        ap(0, 12'h00c, 0, 32'h1ffff);
        for (int f = 0; f < 3; f++) begin
            thermal_shutdown_in <= f == 0;
            pre_thermal_warning_in <= f == 1;
            current_reference_short_in <= f == 2;
            ap(1, 12'h000, 32'((f + 1) << 4));
            i_host.set_blank(1'b0);
            chk(channel_output_out, f == 1 ? 32'hff : 32'h0);
            load(17'h000ff);
            ap(0, 12'h00c, 0, 32'hffff);
            thermal_shutdown_in <= 1'b0;
            pre_thermal_warning_in <= 1'b0;
            current_reference_short_in <= 1'b0;
            i_host.set_blank(1'b1);
            ap(0, 12'h004, 0, 32'(f < 2) << (16 + f), 32'(1) << (16 + f));
            load(17'h000ff);
            ap(0, 12'h004, 0, 32'h0, 32'(1) << (16 + f));
        end
        ap(1, 12'h000, 32'h11);
        i_host.set_blank(1'b0);
        chk(off_state_sink_out, 1'b1);
        repeat (30) @(posedge ref_clk_in);
        chk(off_state_sink_out, 1'b0);
        i_host.set_blank(1'b1);
        load(17'h000ff);
        ap(0, 12'h00c, 0, 32'hf0f0);
        ap(1, 12'h000, 32'h40);
        load(17'h000ff);
        ap(0, 12'h00c, 0, 32'hff);
        load(17'h00000);
        repeat (20) @(posedge ref_clk_in);
        chk(power_save_out, 1'b1);
        i_host.shift_word(17'h000ff);
        chk(power_save_out, 1'b0);
        repeat (25) @(posedge ref_clk_in);
        i_host.pulse_latch();
        ap(0, 12'h008, 0, 32'hff);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        miscompares++;
        finish_test();
    end
endmodule
